//--- dv/pms_power_stage_model.sv
// Behavioural model of the external power stage and supply rails.
`timescale 1ns/100ps
module pms_power_stage_model
  import pms_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic switching_supply_gate,
  input wire logic sys_reg_en,
  input wire pms_ldo_en_t ldo_en,
  input wire logic slow,
  input wire logic [4:0] drop,
  output logic main_uvlo_ok,
  output logic current_sense_pin_hi,
  output pms_rails_t rails_good
);
  logic [4:0] en_v;
  logic [4:0] good;
  logic [5:0] dly;
  logic [5:0] cnt [5];
  logic gate_d, sys_d;

  // Sense resistor sits on the high side in this board model.
  assign current_sense_pin_hi = 1'b1;
  assign en_v = {sys_reg_en, ldo_en};
  assign dly = slow ? 6'h28 : 6'h03;
  // A dropped rail reads not good even while its regulator is enabled.
  assign rails_good = pms_rails_t'(good & ~drop);

  // Lockout clears on the first gate pulse and returns when the
  // regulators shut down; rails go good 4 cycles after enable, or 41 with slow set.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      main_uvlo_ok <= 1'b0;
      gate_d <= 1'b0;
      sys_d <= 1'b0;
      good <= 5'h00;
      cnt <= '{default: 6'h00};
    end else begin
      gate_d <= switching_supply_gate;
      sys_d <= sys_reg_en;
      if (switching_supply_gate && !gate_d) begin
        main_uvlo_ok <= 1'b1;
      end else if (sys_d && !sys_reg_en) begin
        main_uvlo_ok <= 1'b0;
      end
      for (int i = 0; i < 5; i++) begin
        cnt[i] <= !en_v[i] ? 6'h00 : (cnt[i] == dly) ? dly : cnt[i] + 6'h01;
        good[i] <= en_v[i] && cnt[i] == dly;
      end
    end
  end
endmodule : pms_power_stage_model

//--- dv/pms_sequencer_asserts.sv
// Port-level checker for the power manager sequencer.
`timescale 1ns/100ps
module pms_sequencer_asserts
  import pms_pkg::*;
#(
  parameter int STARTUP_CYC = PMS_STARTUP_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic main_uvlo_ok,
  input wire pms_rails_t rails_good,
  input wire logic temp_warn,
  input wire logic switching_supply_gate,
  input wire logic switching_supply_en,
  input wire logic sys_reg_en,
  input wire pms_ldo_en_t ldo_en,
  input wire logic cpu_rst_b,
  input wire logic warn_irq,
  input wire logic [2:0] power_monitor_sel,
  input wire logic [1:0] vreg_sel
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // ========
  // Helper logic
  // Counts cycles above lockout; saturates so a long run cannot wrap.
  logic [23:0] up_cnt_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      up_cnt_r <= 24'h000000;
    end else if (!main_uvlo_ok) begin
      up_cnt_r <= 24'h000000;
    end else if (up_cnt_r != 24'hffffff) begin
      up_cnt_r <= up_cnt_r + 24'h000001;
    end
  end

  // ========
  // Properties
  sequence s_hib_wr;
    reg_wr && reg_addr == PMS_OFS_CTRL && reg_wdata[PMS_CTRL_HIB_REQ]
      && cpu_rst_b;
  endsequence
  sequence s_all_off;
    !switching_supply_en && !sys_reg_en && ldo_en == 4'h0
      && !switching_supply_gate;
  endsequence
  property p_hib;
    s_hib_wr |-> ##[1:4] s_all_off;
  endproperty
  property p_lock;
    !main_uvlo_ok |-> !sys_reg_en;
  endproperty
  property p_start;
    $rose(sys_reg_en) |-> up_cnt_r >= STARTUP_CYC;
  endproperty
  property p_flash;
    $rose(ldo_en.flash_en) |-> sys_reg_en && $past(rails_good.sys_good, 2);
  endproperty
  property p_order;
    ($rose(ldo_en.io_en) |-> $past(rails_good.flash_good, 2))
    and ($rose(ldo_en.analog_en) |-> $past(rails_good.io_good, 2))
    and ($rose(ldo_en.core_en) |-> $past(rails_good.analog_good, 2));
  endproperty
  property p_release;
    $rose(cpu_rst_b) |-> ldo_en == 4'hf && $past(rails_good, 4) == 5'h1f;
  endproperty
  property p_fault;
    cpu_rst_b && (rails_good & 5'h17) != 5'h17 |-> ##[1:4] !cpu_rst_b;
  endproperty
  property p_warn;
    $rose(warn_irq) |-> $past(temp_warn, 2) || $past(temp_warn, 3);
  endproperty
  property p_mon;
    power_monitor_sel != 3'h7;
  endproperty
  property p_vreg;
    vreg_sel != 2'h3;
  endproperty

  a_hib: assert property (p_hib)
    else $error("supply on in hibernate");
  a_lock: assert property (p_lock)
    else $error("regulator on below lockout");
  a_start: assert property (p_start)
    else $error("regulator on too early");
  a_flash: assert property (p_flash)
    else $error("flash on before system good");
  a_order: assert property (p_order)
    else $error("regulator out of order");
  a_release: assert property (p_release)
    else $error("release with rail not good");
  a_fault: assert property (p_fault)
    else $error("no reset on rail loss");
  a_warn: assert property (p_warn)
    else $error("interrupt without warning");
  a_mon: assert property (p_mon)
    else $error("monitor select invalid");
  a_vreg: assert property (p_vreg)
    else $error("regulation code invalid");
endmodule : pms_sequencer_asserts

bind pms_sequencer pms_sequencer_asserts #(.STARTUP_CYC(STARTUP_CYC)) chk_u (
  .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .main_uvlo_ok(main_uvlo_ok), .rails_good(rails_good),
  .temp_warn(temp_warn), .switching_supply_gate(switching_supply_gate),
  .switching_supply_en(switching_supply_en), .sys_reg_en(sys_reg_en),
  .ldo_en(ldo_en), .cpu_rst_b(cpu_rst_b), .warn_irq(warn_irq),
  .power_monitor_sel(power_monitor_sel), .vreg_sel(vreg_sel));

//--- dv/tb_pms_sequencer.sv
// Self-checking testbench for the power manager sequencer.
`timescale 1ns/100ps
module tb_pms_sequencer
  import pms_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic over_temp = 1'b0;
  logic temp_warn = 1'b0;
  logic push_button = 1'b0;
  logic slow = 1'b0;
  logic [4:0] drop = 5'h00;
  logic [7:0] reg_rdata;
  logic uvlo, sense, gate, ss_en, hs, hf, clamp, sys_en, cpu_rst_b, irq;
  logic [2:0] freq_sel, mon_sel;
  logic [1:0] vreg_sel, tref;
  pms_rails_t rails;
  pms_ldo_en_t ldo_en;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;

  // 40 MHz clock.
  always #12.5 clock = ~clock;

  pms_sequencer #(.STARTUP_CYC(50), .LF_TICK_CYC(4)) dut_u (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .main_uvlo_ok(uvlo), .current_sense_pin_hi(sense),
    .current_limit(1'b0), .rails_good(rails), .over_temp(over_temp),
    .temp_warn(temp_warn), .push_button(push_button),
    .switching_supply_gate(gate), .switching_supply_en(ss_en),
    .high_side_sense(hs), .high_freq_mode(hf), .freq_sel(freq_sel),
    .vreg_sel(vreg_sel), .clamp_en(clamp), .sys_reg_en(sys_en),
    .ldo_en(ldo_en), .cpu_rst_b(cpu_rst_b), .warn_irq(irq),
    .power_monitor_sel(mon_sel), .threshold_ref(tref));

  pms_power_stage_model mdl_u (
    .clock(clock), .rst_b(rst_b), .switching_supply_gate(gate),
    .sys_reg_en(sys_en), .ldo_en(ldo_en), .slow(slow), .drop(drop),
    .main_uvlo_ok(uvlo), .current_sense_pin_hi(sense), .rails_good(rails));

  // ========
  // Tasks
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wt

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rdc(input string nm, input logic [3:0] a,
                     input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, exp);
  endtask : rdc

  task automatic wait_run();
    for (int i = 0; i < 20000 && cpu_rst_b !== 1'b1; i++) @(posedge clock);
    wt(1);
    chk("release", 8'(cpu_rst_b), 8'h01);
  endtask : wait_run

  task automatic press();
    @(posedge clock);
    push_button <= 1'b1;
    repeat (4) @(posedge clock);
    push_button <= 1'b0;
  endtask : press

  // Cycle ceiling well above the longest expected run.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end

  // ========
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rdc("timing", PMS_OFS_TIMING, PMS_RST_TIMING);
    wr(PMS_OFS_SWCFG, 8'h0f);
    wait_run();
    rdc("swcfg", PMS_OFS_SWCFG, PMS_RST_SWCFG);
    rdc("status", PMS_OFS_STATUS, 8'hbf);
    chk("vreg", 8'(vreg_sel), 8'(PMS_VREG_15V));
    rdc("unmapped", 4'h7, 8'h00);
    $display("test startup done");
    for (int i = 0; i < 16; i++) begin
      wr(PMS_OFS_SWCFG, 8'(i) | 8'h40 | 8'(i % 4 * 16));
      wt(2);
      chk("freq", {4'h0, hf, freq_sel}, 8'(i));
      chk("clamp", 8'(clamp), 8'h01);
      chk("vreg", 8'(vreg_sel), 8'(i % 4 - i % 4 / 3));
    end
    for (int s = 0; s < 8; s++) begin
      wr(PMS_OFS_MON, 8'(s) | 8'(s % 4 * 16));
      wt(2);
      chk("mon", 8'(mon_sel), (s == 7) ? 8'h00 : 8'(s));
      chk("tref", 8'(tref), 8'(s % 4));
    end
    wr(PMS_OFS_CTRL, 8'h04);
    wt(2);
    chk("ss_off", 8'(ss_en), 8'h00);
    wr(PMS_OFS_CTRL, 8'h00);
    $display("test config done");
    wr(PMS_OFS_MASK, 8'h02);
    @(posedge clock);
    temp_warn <= 1'b1;
    wt(6);
    chk("irq_on", 8'(irq), 8'h01);
    wr(PMS_OFS_MASK, 8'h00);
    wt(3);
    chk("irq_off", 8'(irq), 8'h00);
    @(posedge clock);
    temp_warn <= 1'b0;
    rdc("flt_warn", PMS_OFS_FAULT, 8'h04);
    wr(PMS_OFS_FAULT, 8'hff);
    rdc("flt_clr", PMS_OFS_FAULT, 8'h00);
    wr(PMS_OFS_MASK, 8'h01);
    @(posedge clock);
    over_temp <= 1'b1;
    wt(10);
    chk("ot_mask", 8'(cpu_rst_b), 8'h01);
    wr(PMS_OFS_MASK, 8'h00);
    wt(4);
    chk("ot_rst", 8'(cpu_rst_b), 8'h00);
    @(posedge clock);
    over_temp <= 1'b0;
    wait_run();
    rdc("flt_ot", PMS_OFS_FAULT, 8'h02);
    wr(PMS_OFS_FAULT, 8'hff);
    $display("test temperature done");
    @(posedge clock);
    drop <= 5'h04;
    wt(6);
    chk("uv_rst", 8'(cpu_rst_b), 8'h00);
    @(posedge clock);
    drop <= 5'h00;
    wait_run();
    rdc("flt_uv", PMS_OFS_FAULT, 8'h01);
    wr(PMS_OFS_FAULT, 8'hff);
    $display("test rail fault done");
    wr(PMS_OFS_TIMING, 8'h30);
    wr(PMS_OFS_SWCFG, 8'h20);
    wr(PMS_OFS_CTRL, 8'h01);
    wt(4);
    chk("hib_fw", {gate, ss_en, sys_en, ldo_en, 1'b0}, 8'h00);
    wt(400);
    chk("hib_stay", 8'(sys_en), 8'h00);
    wait_run();
    rdc("flt_hib", PMS_OFS_FAULT, 8'h08);
    rdc("swcfg_def", PMS_OFS_SWCFG, PMS_RST_SWCFG);
    wr(PMS_OFS_FAULT, 8'hff);
    wr(PMS_OFS_TIMING, 8'h3f);
    wr(PMS_OFS_CTRL, 8'h02);
    press();
    wt(4);
    chk("hib_btn", {gate, ss_en, sys_en, ldo_en, 1'b0}, 8'h00);
    wt(1000);
    chk("hib_inf", 8'(sys_en), 8'h00);
    @(posedge clock);
    slow <= 1'b1;
    press();
    wait_run();
    wr(PMS_OFS_STATUS, 8'h00);
    rdc("status_ro", PMS_OFS_STATUS, 8'hbf);
    $display("test hibernate done");
    results();
  end
endmodule : tb_pms_sequencer

//--- hw/pms_pkg.sv
// Package of constants and types for the power manager sequencer.
package pms_pkg;

  // ========
  // Register offsets (word index).
  localparam logic [3:0] PMS_OFS_CTRL = 4'h0;
  localparam logic [3:0] PMS_OFS_SWCFG = 4'h1;
  localparam logic [3:0] PMS_OFS_TIMING = 4'h2;
  localparam logic [3:0] PMS_OFS_MASK = 4'h3;
  localparam logic [3:0] PMS_OFS_STATUS = 4'h4;
  localparam logic [3:0] PMS_OFS_FAULT = 4'h5;
  localparam logic [3:0] PMS_OFS_MON = 4'h6;

  // ========
  // Field positions.
  localparam int PMS_CTRL_HIB_REQ = 0;
  localparam int PMS_CTRL_BTN_EN = 1;
  localparam int PMS_CTRL_SS_DIS = 2;
  localparam int PMS_SW_FREQ_LSB = 0;
  localparam int PMS_SW_HF_MODE = 3;
  localparam int PMS_SW_VREG_LSB = 4;
  localparam int PMS_SW_CLAMP_EN = 6;
  localparam int PMS_TIM_WAKE_LSB = 0;
  localparam int PMS_TIM_POR_LSB = 4;
  localparam int PMS_MASK_OT_RST = 0;
  localparam int PMS_MASK_WARN = 1;
  localparam int PMS_FLT_UV = 0;
  localparam int PMS_FLT_OT = 1;
  localparam int PMS_FLT_WARN = 2;
  localparam int PMS_FLT_HIB = 3;
  localparam int PMS_MON_SEL_LSB = 0;
  localparam int PMS_MON_REF_LSB = 4;

  // ========
  // Reset values.
  localparam logic [7:0] PMS_RST_SWCFG = 8'h00;
  localparam logic [7:0] PMS_RST_TIMING = 8'h33;
  localparam logic [7:0] PMS_RST_MASK = 8'h00;
  localparam logic [7:0] PMS_RST_MON = 8'h00;

  // Regulation target codes: reset value is the highest, 15 V.
  localparam logic [1:0] PMS_VREG_15V = 2'h0;
  localparam logic [1:0] PMS_VREG_12V = 2'h1;
  localparam logic [1:0] PMS_VREG_9V = 2'h2;

  // Wake timer code that means "never expire".
  localparam logic [3:0] PMS_WAKE_INFINITE = 4'hf;
  localparam logic [3:0] PMS_WAKE_MAX_CODE = 4'h6;

  // ========
  // Timing. Clock is 40 MHz.
  localparam int PMS_CLK_MHZ = 40;
  localparam int PMS_CLK_HZ = PMS_CLK_MHZ * 1000000;
  localparam int PMS_BLANK_NS = 200;
  localparam int PMS_BLANK_CYC = (PMS_BLANK_NS * PMS_CLK_MHZ + 999) / 1000;
  localparam int PMS_STARTUP_MS = 6;
  localparam int PMS_STARTUP_CYC = PMS_STARTUP_MS * (PMS_CLK_HZ / 1000);
  localparam int PMS_SAFE_FREQ_DHZ = 95;
  localparam int PMS_SAFE_HALF_CYC = PMS_CLK_HZ * 10 / PMS_SAFE_FREQ_DHZ / 2;
  localparam int PMS_DEF_FREQ_KHZ = 45;
  localparam int PMS_DEF_HALF_CYC = PMS_CLK_HZ / 1000 / PMS_DEF_FREQ_KHZ / 2;
  localparam int PMS_WAKE_MIN_MS = 125;
  localparam int PMS_WAKE_MAX_S = 8;
  localparam int PMS_LF_TICK_MS = 1;
  localparam int PMS_LF_TICK_CYC = PMS_LF_TICK_MS * (PMS_CLK_HZ / 1000);

  // Frequency tables in kHz, eight settings per mode.
  localparam int PMS_HF_KHZ [8] = '{181, 200, 228, 267, 300, 350, 400, 500};
  localparam int PMS_LF_KHZ [8] = '{45, 50, 56, 64, 75, 90, 100, 125};

  // ========
  // Types.
  typedef enum logic [2:0] {
    PMS_ST_SAFE, PMS_ST_START, PMS_ST_SYS, PMS_ST_RAILS, PMS_ST_POR,
    PMS_ST_RUN, PMS_ST_HIB
  } pms_state_t;

  typedef struct packed {
    logic sys_good;
    logic flash_good;
    logic io_good;
    logic analog_good;
    logic core_good;
  } pms_rails_t;

  typedef struct packed {
    logic flash_en;
    logic io_en;
    logic analog_en;
    logic core_en;
  } pms_ldo_en_t;

endpackage : pms_pkg

//--- hw/pms_sequencer.sv
// Power manager sequencer: startup, supervision, hibernate and registers.
//
// Overview of operation
// [RULE1] Latch high or low side sense at startup.
// [RULE2] Switch at safe frequency until lockout clears.
// [RULE3] Default frequency for 6 ms before regulators.
// [RULE4] Eight frequency settings per mode.
// [RULE5] Regulation target defaults highest, two lower settings.
// [RULE6] Firmware programs target, mode, frequency, clamp.
// [RULE7] Firmware may disable switcher with direct supply.
// [RULE8] System rail good starts remaining regulators in turn.
// [RULE9] Release processor when rails good and timer done.
// [RULE10] Rail drop records fault, holds processor reset.
// [RULE11] Maskable over-temperature fault resets processor.
// [RULE12] Fault flags survive processor reset.
// [RULE13] Warning temperature raises maskable interrupt.
// [RULE14] Hibernate by firmware or enabled button.
// [RULE15] Hibernate keeps switcher and regulators off.
// [RULE16] Wake on timer, infinite setting, or button; the code needs button enable set at hibernate entry.
// [RULE17] Wake reruns startup, keeps only fault flags; the code also keeps the timing register.
// [RULE18] Monitor select picks one of seven sources.
// [RULE19] Two-bit threshold reference select.
// [RULE20] Blank current limit after each turn-on.
// [RULE21] Order flash, io, analog, core on power good.
// [RULE22] Slow tick counts wake and reset intervals.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module pms_sequencer
  import pms_pkg::*;
#(
  parameter int STARTUP_CYC = PMS_STARTUP_CYC,
  parameter int LF_TICK_CYC = PMS_LF_TICK_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic main_uvlo_ok,
  input wire logic current_sense_pin_hi,
  input wire logic current_limit,
  input wire pms_rails_t rails_good,
  input wire logic over_temp,
  input wire logic temp_warn,
  input wire logic push_button,
  output logic switching_supply_gate,
  output logic switching_supply_en,
  output logic high_side_sense,
  output logic high_freq_mode,
  output logic [2:0] freq_sel,
  output logic [1:0] vreg_sel,
  output logic clamp_en,
  output logic sys_reg_en,
  output pms_ldo_en_t ldo_en,
  output logic cpu_rst_b,
  output logic warn_irq,
  output logic [2:0] power_monitor_sel,
  output logic [1:0] threshold_ref
);

  // ========
  // Input synchronisers.
  logic [8:0] sync1_r;
  logic [8:0] sync2_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
    end else begin
      sync1_r <= {main_uvlo_ok, current_sense_pin_hi, rails_good, over_temp,
                  temp_warn};
      sync2_r <= sync1_r;
    end
  end
  logic uvlo_ok_s, sense_hi_s, ot_s, warn_s;
  pms_rails_t rails_s;
  assign {uvlo_ok_s, sense_hi_s, rails_s, ot_s, warn_s} = sync2_r;

  logic [1:0] btn_sync_r;
  logic btn_prev_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      btn_sync_r <= 2'h0;
      btn_prev_r <= 1'b0;
    end else begin
      btn_sync_r <= {btn_sync_r[0], push_button};
      btn_prev_r <= btn_sync_r[1];
    end
  end
  logic btn_evt;
  assign btn_evt = btn_sync_r[1] && !btn_prev_r;

  // Current limit comparator also crosses domains.
  logic [1:0] ilim_sync_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ilim_sync_r <= 2'h0;
    end else begin
      ilim_sync_r <= {ilim_sync_r[0], current_limit};
    end
  end

  // ========
  // Registers.
  logic [7:0] ctrl_r, swcfg_r, timing_r, mask_r, fault_r, mon_r;
  logic wr_ctrl, wr_sw, wr_tim, wr_mask, wr_fault, wr_mon;
  assign wr_ctrl = reg_wr && reg_addr == PMS_OFS_CTRL;
  assign wr_sw = reg_wr && reg_addr == PMS_OFS_SWCFG;
  assign wr_tim = reg_wr && reg_addr == PMS_OFS_TIMING;
  assign wr_mask = reg_wr && reg_addr == PMS_OFS_MASK;
  assign wr_fault = reg_wr && reg_addr == PMS_OFS_FAULT;
  assign wr_mon = reg_wr && reg_addr == PMS_OFS_MON;

  pms_state_t state_r;
  logic cpu_held;
  assign cpu_held = state_r != PMS_ST_RUN;

  // Configuration other than the timing register returns to defaults whenever
  // the processor is held, so a wake from hibernate starts from a clean setting.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= 8'h00;
      swcfg_r <= PMS_RST_SWCFG;
      timing_r <= PMS_RST_TIMING;
      mask_r <= PMS_RST_MASK;
      mon_r <= PMS_RST_MON;
    end else if (cpu_held) begin
      ctrl_r <= 8'h00;  // RULE17
      swcfg_r <= PMS_RST_SWCFG;  // RULE5
      mask_r <= PMS_RST_MASK;
      mon_r <= PMS_RST_MON;
    end else begin
      if (wr_ctrl) ctrl_r <= {5'h00, reg_wdata[2:0]};  // RULE7
      if (wr_sw) swcfg_r <= {1'b0, reg_wdata[6:0]};  // RULE6
      if (wr_tim) timing_r <= reg_wdata;
      if (wr_mask) mask_r <= {6'h00, reg_wdata[1:0]};
      if (wr_mon) mon_r <= {2'h0, reg_wdata[5:0]};
    end
  end

  // ========
  // Slow tick standing in for the always-on low-frequency oscillator.
  logic [15:0] lf_cnt_r;
  logic lf_tick;
  assign lf_tick = lf_cnt_r == 16'(LF_TICK_CYC - 1);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lf_cnt_r <= 16'h0000;
    end else begin
      lf_cnt_r <= lf_tick ? 16'h0000 : lf_cnt_r + 16'h0001;  // RULE22
    end
  end

  // Wake time in ticks: 125 ms doubled per code step, capped at 8 s.
  function automatic logic [13:0] pms_wake_ticks(input logic [3:0] code);
    logic [3:0] c;
    c = (code > PMS_WAKE_MAX_CODE) ? PMS_WAKE_MAX_CODE : code;
    return 14'(PMS_WAKE_MIN_MS / PMS_LF_TICK_MS) << c;
  endfunction : pms_wake_ticks

  // ========
  // Sequencer.
  logic [22:0] seq_cnt_r;
  logic [13:0] tick_cnt_r;
  logic [1:0] ldo_idx_r;
  logic hib_req, wake_evt;
  assign hib_req = ctrl_r[PMS_CTRL_HIB_REQ] ||
                   (ctrl_r[PMS_CTRL_BTN_EN] && btn_evt);  // RULE14
  logic ot_rst;
  assign ot_rst = ot_s && !mask_r[PMS_MASK_OT_RST];  // RULE11
  logic rails_all;
  assign rails_all = &rails_s;
  logic btn_en_hib_r;
  assign wake_evt = (timing_r[3:0] != PMS_WAKE_INFINITE &&
                     tick_cnt_r >= pms_wake_ticks(timing_r[3:0])) ||
                    (btn_en_hib_r && btn_evt);  // RULE16

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= PMS_ST_SAFE;
      seq_cnt_r <= 23'h000000;
      tick_cnt_r <= 14'h0000;
      ldo_idx_r <= 2'h0;
      btn_en_hib_r <= 1'b0;
      high_side_sense <= 1'b0;
    end else begin
      case (state_r)
        PMS_ST_SAFE: begin
          high_side_sense <= sense_hi_s;  // RULE1
          seq_cnt_r <= 23'h000000;
          if (uvlo_ok_s) state_r <= PMS_ST_START;  // RULE2
        end
        PMS_ST_START: begin
          seq_cnt_r <= seq_cnt_r + 23'h000001;
          if (seq_cnt_r >= 23'(STARTUP_CYC - 1)) begin
            state_r <= PMS_ST_SYS;  // RULE3
          end
        end
        PMS_ST_SYS: begin
          ldo_idx_r <= 2'h0;
          if (rails_s.sys_good) state_r <= PMS_ST_RAILS;  // RULE8
        end
        PMS_ST_RAILS: begin
          // Each step waits for the previous rail's good flag.
          if (!rails_s.sys_good) begin
            state_r <= PMS_ST_SYS;
          end else if (ldo_idx_r == 2'h3 && rails_s.core_good) begin
            state_r <= PMS_ST_POR;
            tick_cnt_r <= 14'h0000;
          end else if ((ldo_idx_r == 2'h0 && rails_s.flash_good) ||
                       (ldo_idx_r == 2'h1 && rails_s.io_good) ||
                       (ldo_idx_r == 2'h2 && rails_s.analog_good)) begin
            ldo_idx_r <= ldo_idx_r + 2'h1;  // RULE21
          end
        end
        PMS_ST_POR: begin
          if (!rails_all || ot_rst) begin
            tick_cnt_r <= 14'h0000;  // RULE10
          end else if (lf_tick) begin
            tick_cnt_r <= tick_cnt_r + 14'h0001;
          end
          if (rails_all && !ot_rst && tick_cnt_r >= {10'h000, timing_r[7:4]})
          begin
            state_r <= PMS_ST_RUN;  // RULE9
          end
        end
        PMS_ST_RUN: begin
          tick_cnt_r <= 14'h0000;
          if (!rails_all || ot_rst) begin
            state_r <= PMS_ST_POR;  // RULE10
          end else if (hib_req) begin
            btn_en_hib_r <= ctrl_r[PMS_CTRL_BTN_EN];
            state_r <= PMS_ST_HIB;
          end
        end
        PMS_ST_HIB: begin
          if (lf_tick) tick_cnt_r <= tick_cnt_r + 14'h0001;  // RULE22
          if (wake_evt) begin
            tick_cnt_r <= 14'h0000;
            state_r <= PMS_ST_SAFE;  // RULE17
          end
        end
        default: state_r <= PMS_ST_SAFE;
      endcase
    end
  end

  // ========
  // Persistent fault flags: only an asynchronous reset or a firmware write of ones
  // clears them, and a new event wins over a software clear in the same cycle.
  logic [3:0] flt_set;
  assign flt_set = {state_r == PMS_ST_RUN && hib_req,
                    warn_s,
                    state_r == PMS_ST_RUN && ot_rst,
                    state_r == PMS_ST_RUN && !rails_all};
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fault_r <= 8'h00;
    end else begin
      fault_r[3:0] <= (fault_r[3:0] & ~(wr_fault && !cpu_held ?
                       reg_wdata[3:0] : 4'h0)) | flt_set;  // RULE12
    end
  end

  // ========
  // Switching supply output: frequency select and gate pulse generator.
  function automatic logic [11:0] pms_half_period(input logic hf,
                                                   input logic [2:0] sel);
    int khz;
    khz = hf ? PMS_HF_KHZ[sel] : PMS_LF_KHZ[sel];
    return 12'(PMS_CLK_HZ / 1000 / khz / 2);  // RULE4
  endfunction : pms_half_period

  logic [22:0] sw_cnt_r;
  logic [22:0] sw_half;
  logic [7:0] blank_cnt_r;
  always_comb begin
    case (state_r)
      PMS_ST_SAFE: sw_half = 23'(PMS_SAFE_HALF_CYC);  // RULE2
      PMS_ST_START, PMS_ST_SYS, PMS_ST_RAILS, PMS_ST_POR:
        sw_half = 23'(PMS_DEF_HALF_CYC);  // RULE3
      default: sw_half = {11'h000, pms_half_period(swcfg_r[PMS_SW_HF_MODE],
                                   swcfg_r[2:0])};
    endcase
  end

  logic sw_active;
  assign sw_active = state_r != PMS_ST_HIB &&
                     !(state_r == PMS_ST_RUN && ctrl_r[PMS_CTRL_SS_DIS]);
  logic ilim_hit;
  assign ilim_hit = ilim_sync_r[1] && blank_cnt_r == 8'h00;  // RULE20

  // Gate stays high for half a period unless the limit trips outside blanking.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sw_cnt_r <= 23'h000000;
      switching_supply_gate <= 1'b0;
      blank_cnt_r <= 8'h00;
    end else if (!sw_active) begin
      sw_cnt_r <= 23'h000000;
      switching_supply_gate <= 1'b0;  // RULE15
      blank_cnt_r <= 8'h00;
    end else begin
      sw_cnt_r <= (sw_cnt_r >= (sw_half << 1) - 23'h1) ? 23'h0 :
                  sw_cnt_r + 23'h1;
      if (sw_cnt_r == 23'h0) begin
        switching_supply_gate <= 1'b1;
        blank_cnt_r <= 8'(PMS_BLANK_CYC);  // RULE20
      end else begin
        if (blank_cnt_r != 8'h00) blank_cnt_r <= blank_cnt_r - 8'h01;
        if (sw_cnt_r >= sw_half || ilim_hit) switching_supply_gate <= 1'b0;
      end
    end
  end

  // ========
  // Registered outputs.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      switching_supply_en <= 1'b0;
      high_freq_mode <= 1'b0;
      freq_sel <= 3'h0;
      vreg_sel <= PMS_VREG_15V;
      clamp_en <= 1'b0;
      sys_reg_en <= 1'b0;
      ldo_en <= '0;
      cpu_rst_b <= 1'b0;
      warn_irq <= 1'b0;
      power_monitor_sel <= 3'h0;
      threshold_ref <= 2'h0;
    end else begin
      switching_supply_en <= sw_active;  // RULE15
      high_freq_mode <= swcfg_r[PMS_SW_HF_MODE];
      freq_sel <= swcfg_r[2:0];  // RULE4
      vreg_sel <= (swcfg_r[5:4] > PMS_VREG_9V) ? PMS_VREG_9V :
                  swcfg_r[5:4];  // RULE5
      clamp_en <= swcfg_r[PMS_SW_CLAMP_EN];
      sys_reg_en <= state_r inside {PMS_ST_SYS, PMS_ST_RAILS, PMS_ST_POR,
                                    PMS_ST_RUN};  // RULE3
      ldo_en.flash_en <= state_r inside {PMS_ST_RAILS, PMS_ST_POR,
                                         PMS_ST_RUN};  // RULE21
      ldo_en.io_en <= (state_r == PMS_ST_RAILS && ldo_idx_r >= 2'h1) ||
                      state_r inside {PMS_ST_POR, PMS_ST_RUN};
      ldo_en.analog_en <= (state_r == PMS_ST_RAILS && ldo_idx_r >= 2'h2) ||
                          state_r inside {PMS_ST_POR, PMS_ST_RUN};
      ldo_en.core_en <= (state_r == PMS_ST_RAILS && ldo_idx_r == 2'h3) ||
                        state_r inside {PMS_ST_POR, PMS_ST_RUN};
      cpu_rst_b <= state_r == PMS_ST_RUN && rails_all && !ot_rst;  // RULE9
      warn_irq <= fault_r[PMS_FLT_WARN] && mask_r[PMS_MASK_WARN];  // RULE13
      power_monitor_sel <= (mon_r[2:0] == 3'h7) ? 3'h0 : mon_r[2:0];  // RULE18
      threshold_ref <= mon_r[5:4];  // RULE19
    end
  end

  // ========
  // Read port: data stands one cycle after the strobe, zero otherwise.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        PMS_OFS_CTRL: reg_rdata <= ctrl_r;
        PMS_OFS_SWCFG: reg_rdata <= swcfg_r;
        PMS_OFS_TIMING: reg_rdata <= timing_r;
        PMS_OFS_MASK: reg_rdata <= mask_r;
        PMS_OFS_STATUS: reg_rdata <= {high_side_sense, 1'b0,
                                      state_r == PMS_ST_RUN, rails_s};
        PMS_OFS_FAULT: reg_rdata <= fault_r;
        PMS_OFS_MON: reg_rdata <= mon_r;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : pms_sequencer
